// ===== hdl/urb_rx_buffer.sv
// urb_rx_buffer.sv: receive buffer, status flags and APB register slave
// assumes: a bit-sampling front end on i_clk delivers frame strobes; APB master on i_clk
// Notes on behaviour
// - nine-bit mode keeps ninth bit with entry
// - receive-complete high while unread entry exists
// - disabling receiver empties the buffer
// - interrupt request is a level while flagged
// - only data reads and disabling the receiver clear receive-complete
// - error flags stored per entry, oldest shown
// - status writes never alter error flags
// - error flags raise no interrupt
// - frame error set when stop bit zero
// - only first stop bit is checked
// - two entries; overrun on full plus parked frame plus start
// - overrun kept until next frame stored
// - parity flag zero when checking disabled
// - parity checked when enable bit set
// - parity flag captured at frame arrival
// - disable is immediate, pin released
// - frame stored after first stop bit
// - unused upper data bits read zero
`timescale 1ns/10ps
`include "urb_cfg.svh"
module urb_rx_buffer (
  input  wire logic        i_clk,
  input  wire logic        i_sys_rst,
  // apb slave
  input  wire logic        i_psel,
  input  wire logic        i_penable,
  input  wire logic        i_pwrite,
  input  wire logic [11:0] i_paddr,
  input  wire logic [31:0] i_pwdata,
  input  wire logic [3:0]  i_pstrb,
  output logic [31:0]      o_prdata,
  output logic             o_pready,
  output logic             o_pslverr,
  // front end
  input  wire logic        i_frame_done,
  input  wire logic [7:0]  i_frame_data,
  input  wire logic        i_frame_bit9,
  input  wire logic        i_frame_stop1,
  input  wire logic        i_frame_parity,
  input  wire logic        i_start_det,
  // to front end and pin mux
  output logic             o_rx_enable,
  output logic             o_rx_abort,
  output logic [2:0]       o_char_size,
  output logic             o_two_stop,
  output logic             o_tx_bit9,
  output logic             o_rx_irq
);
  import urb_pkg::*;

  // ----------------------------------------------------------------
  // bus decode
  // ----------------------------------------------------------------
  function automatic logic hit(input logic [11:0] a, input logic [11:0] ofs);
    hit = (a == ofs);
  endfunction : hit

  logic acc;
  logic wr;
  logic rd;
  logic mapped;
  assign acc    = i_psel && i_penable;
  assign wr     = acc && i_pwrite && i_pstrb[0];
  assign rd     = acc && !i_pwrite;
  assign mapped = hit(i_paddr, `URB_OFS_STATUS) || hit(i_paddr, `URB_OFS_CTRL_B) ||
                  hit(i_paddr, `URB_OFS_CTRL_C) || hit(i_paddr, `URB_OFS_DATA);
  assign o_pready  = 1'b1;
  assign o_pslverr = acc && !mapped;

  // ----------------------------------------------------------------
  // control registers
  // ----------------------------------------------------------------
  logic [7:0] ctrl_b_q;
  logic [7:0] ctrl_c_q;
  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      ctrl_b_q <= `URB_RST_CTRL_B;
    end else if (wr && hit(i_paddr, `URB_OFS_CTRL_B)) begin
      // the ninth received bit is buffer state, not writable
      ctrl_b_q <= i_pwdata[7:0];
    end
  end
  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      ctrl_c_q <= `URB_RST_CTRL_C;
    end else if (wr && hit(i_paddr, `URB_OFS_CTRL_C)) begin
      ctrl_c_q <= i_pwdata[7:0];
    end
  end

  logic       rx_en;
  logic       par_en;
  logic [2:0] size;
  assign rx_en  = ctrl_b_q[`URB_CB_RECEIVER_ENABLE];
  assign par_en = ctrl_c_q[`URB_CC_PEN];
  assign size   = {ctrl_b_q[`URB_CB_SIZE2], ctrl_c_q[`URB_CC_SIZE_HI], ctrl_c_q[`URB_CC_SIZE_LO]};
  assign o_rx_enable = rx_en;
  assign o_rx_abort  = !rx_en;
  assign o_char_size = size;
  assign o_two_stop  = ctrl_c_q[`URB_CC_STOP2];
  assign o_tx_bit9   = ctrl_b_q[`URB_CB_TX9];

  // ----------------------------------------------------------------
  // frame capture
  // ----------------------------------------------------------------
  logic par_bad;
  urb_parity u_parity (
    .i_data    (i_frame_data),
    .i_bit9    (i_frame_bit9),
    .i_size    (size),
    .i_par_bit (i_frame_parity),
    .i_odd     (ctrl_c_q[`URB_CC_PODD]),
    .o_err     (par_bad)
  );

  urb_fill_t fill_q;
  logic      wptr_q;
  logic      rptr_q;
  logic      pend_q;      // frame waiting in the shift register
  urb_entry_t pend_ent_q;
  logic      lost_q;      // a frame was lost before the next stored one
  logic      full;
  logic      pop;
  logic      push;
  urb_entry_t new_ent;

  assign full = (fill_q == URB_TWO);
  assign pop  = rd && hit(i_paddr, `URB_OFS_DATA) && fill_q != URB_EMPTY;

  always_comb begin
    new_ent.fe   = !i_frame_stop1;
    new_ent.data_overrun_flag  = 1'b0;
    new_ent.parity_error_flag  = par_en && par_bad;
    new_ent.bit9 = (size == `URB_SIZE_NINE) ? i_frame_bit9 : 1'b0;
    new_ent.data = i_frame_data;
    case (size)
      `URB_SIZE_FIVE:  new_ent.data = {3'h0, i_frame_data[4:0]};
      `URB_SIZE_SIX:   new_ent.data = {2'h0, i_frame_data[5:0]};
      `URB_SIZE_SEVEN: new_ent.data = {1'b0, i_frame_data[6:0]};
      default: new_ent.data = i_frame_data;
    endcase
  end

  // a completed frame parks in the shift register while the buffer is full
  always_ff @(posedge i_clk) begin
    if (i_sys_rst || !rx_en) begin
      pend_q <= 1'b0;
    end else if (i_frame_done && rx_en && ((full && !pop) || pend_q)) begin
      // a frame finishing while the parked one moves on takes its place
      pend_q <= 1'b1;
    end else if (push) begin
      pend_q <= 1'b0;
    end
  end
  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      pend_ent_q <= '0;
    end else if (i_frame_done && !(pend_q && i_start_det)) begin
      pend_ent_q <= new_ent;
    end
  end

  // the overrun start pulse holds back the waiting frame; the next finished frame overwrites it
  logic overrun;
  assign overrun = rx_en && full && pend_q && i_start_det && !pop;

  always_ff @(posedge i_clk) begin
    if (i_sys_rst || !rx_en) begin
      lost_q <= 1'b0;
    end else if (overrun) begin
      lost_q <= 1'b1;
    end else if (push) begin
      lost_q <= 1'b0;
    end
  end

  logic       push_pend;
  urb_entry_t push_ent;
  assign push_pend = pend_q && (!full || pop) && !overrun;
  assign push      = rx_en && (push_pend || (i_frame_done && !pend_q && (!full || pop)));
  always_comb begin
    push_ent     = push_pend ? pend_ent_q : new_ent;
    push_ent.data_overrun_flag = lost_q || overrun;
  end

  // ----------------------------------------------------------------
  // buffer pointers and fill level
  // ----------------------------------------------------------------
  always_ff @(posedge i_clk) begin
    if (i_sys_rst || !rx_en) begin
      fill_q <= URB_EMPTY;
    end else begin
      case (fill_q)
        URB_EMPTY: fill_q <= push ? URB_ONE : URB_EMPTY;
        URB_ONE:   fill_q <= (push && !pop) ? URB_TWO : ((pop && !push) ? URB_EMPTY : URB_ONE);
        URB_TWO:   fill_q <= (pop && !push) ? URB_ONE : URB_TWO;
        default:   fill_q <= URB_EMPTY;
      endcase
    end
  end
  always_ff @(posedge i_clk) begin
    if (i_sys_rst || !rx_en) begin
      wptr_q <= 1'b0;
    end else if (push) begin
      wptr_q <= !wptr_q;
    end
  end
  always_ff @(posedge i_clk) begin
    if (i_sys_rst || !rx_en) begin
      rptr_q <= 1'b0;
    end else if (pop) begin
      rptr_q <= !rptr_q;
    end
  end

  urb_entry_t head;
  urb_mem u_mem (
    .i_clk   (i_clk),
    .i_we    (push),
    .i_waddr (wptr_q),
    .i_wdata (push_ent),
    .i_raddr (pop ? !rptr_q : rptr_q),
    .o_rdata (head)
  );

  logic receive_complete_flag;
  assign receive_complete_flag      = (fill_q != URB_EMPTY);
  assign o_rx_irq = receive_complete_flag && ctrl_b_q[`URB_CB_RECEIVE_COMPLETE_IRQ_ENABLE];

  // ----------------------------------------------------------------
  // read data
  // ----------------------------------------------------------------
  logic [7:0] status_v;
  logic [7:0] ctrl_b_v;
  always_comb begin
    status_v                = 8'h00;
    status_v[`URB_ST_RXC]   = receive_complete_flag;
    status_v[`URB_ST_FE]    = receive_complete_flag && head.fe;
    status_v[`URB_ST_DOR]   = receive_complete_flag && head.data_overrun_flag;
    status_v[`URB_ST_UPE]   = receive_complete_flag && head.parity_error_flag;
    ctrl_b_v                = ctrl_b_q;
    ctrl_b_v[`URB_CB_RX9]   = receive_complete_flag && head.bit9;
  end

  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      o_prdata <= 32'h0000_0000;
    end else if (i_psel && !i_penable && !i_pwrite) begin
      // status writes are ignored, so the error flags stay buffer state
      case (1'b1)
        hit(i_paddr, `URB_OFS_STATUS): o_prdata <= {24'h00_0000, status_v};
        hit(i_paddr, `URB_OFS_CTRL_B): o_prdata <= {24'h00_0000, ctrl_b_v};
        hit(i_paddr, `URB_OFS_CTRL_C): o_prdata <= {24'h00_0000, ctrl_c_q};
        hit(i_paddr, `URB_OFS_DATA):   o_prdata <= {24'h00_0000, receive_complete_flag ? head.data : 8'h00};
        default:                       o_prdata <= 32'h0000_0000;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  a_rxc_level: assert property (@(posedge i_clk) disable iff (i_sys_rst)
    status_v[`URB_ST_RXC] == (fill_q != URB_EMPTY)) else $error("rxc does not follow fill");
  a_flush_off: assert property (@(posedge i_clk) disable iff (i_sys_rst)
    $fell(rx_en) |=> fill_q == URB_EMPTY && !pend_q) else $error("disable did not flush");
  a_irq_level: assert property (@(posedge i_clk) disable iff (i_sys_rst)
    o_rx_irq == (receive_complete_flag && ctrl_b_q[`URB_CB_RECEIVE_COMPLETE_IRQ_ENABLE])) else $error("irq not level of rxc");
  a_rxc_hold: assert property (@(posedge i_clk) disable iff (i_sys_rst)
    receive_complete_flag && !pop && rx_en |=> receive_complete_flag) else $error("rxc cleared without read");
  a_no_err_irq: assert property (@(posedge i_clk) disable iff (i_sys_rst)
    !receive_complete_flag |-> !o_rx_irq) else $error("irq without data");
  a_upe_off: assert property (@(posedge i_clk) disable iff (i_sys_rst)
    push && !push_pend && !par_en |-> !push_ent.parity_error_flag) else $error("parity flag while disabled");
  a_overrun_hold: assert property (@(posedge i_clk) disable iff (i_sys_rst)
    overrun |=> lost_q) else $error("overrun not recorded");
  a_dor_clear: assert property (@(posedge i_clk) disable iff (i_sys_rst)
    push && !overrun |=> !lost_q) else $error("overrun not cleared by store");
  a_fill_bound: assert property (@(posedge i_clk) disable iff (i_sys_rst)
    full && !pop |-> !push) else $error("write into full buffer");
  a_fe_stop: assert property (@(posedge i_clk) disable iff (i_sys_rst)
    i_frame_done |-> new_ent.fe == !i_frame_stop1) else $error("frame error mismatch");

  // ----------------------------------------------------------------
  // checks: fill level, flush and interrupt
  // ----------------------------------------------------------------
  a_rxc_push: assert property (@(posedge i_clk) disable iff (i_sys_rst)
    push |=> receive_complete_flag) else $error("stored frame not flagged");
  a_rxc_drain: assert property (@(posedge i_clk) disable iff (i_sys_rst)
    fill_q == URB_ONE && pop && !push |=> !receive_complete_flag) else $error("flag kept after last read");
  a_flush_state: assert property (@(posedge i_clk) disable iff (i_sys_rst)
    !rx_en |=> fill_q == URB_EMPTY && !pend_q && !lost_q) else $error("disabled receiver kept data");
  a_irq_gate: assert property (@(posedge i_clk) disable iff (i_sys_rst)
    !ctrl_b_q[`URB_CB_RECEIVE_COMPLETE_IRQ_ENABLE] |-> !o_rx_irq) else $error("irq while masked");
  a_irq_stay: assert property (@(posedge i_clk) disable iff (i_sys_rst)
    o_rx_irq && !pop && rx_en |=> receive_complete_flag) else $error("irq source vanished without read");
  a_pop_nonempty: assert property (@(posedge i_clk) disable iff (i_sys_rst)
    pop |-> receive_complete_flag) else $error("read advanced an empty buffer");
  a_no_push_off: assert property (@(posedge i_clk) disable iff (i_sys_rst)
    !rx_en |-> !push) else $error("store while disabled");
  a_abort_pair: assert property (@(posedge i_clk) disable iff (i_sys_rst)
    o_rx_abort != o_rx_enable) else $error("abort and enable agree");
  // pointers agree with the fill level, so a stale head can never be shown
  a_ptr_level: assert property (@(posedge i_clk) disable iff (i_sys_rst)
    (fill_q == URB_ONE) == (wptr_q != rptr_q)) else $error("pointers disagree with fill");
  a_status_ro: assert property (@(posedge i_clk) disable iff (i_sys_rst)
    wr && hit(i_paddr, `URB_OFS_STATUS) && rx_en && !push && !overrun |=> $stable(fill_q) && $stable(lost_q))
    else $error("status write changed buffer state");

  // ----------------------------------------------------------------
  // checks: capture, masking and overrun
  // ----------------------------------------------------------------
  a_bit9_mask: assert property (@(posedge i_clk) disable iff (i_sys_rst)
    push && !push_pend && size != `URB_SIZE_NINE |-> !push_ent.bit9) else $error("ninth bit outside nine-bit mode");
  a_data_seven: assert property (@(posedge i_clk) disable iff (i_sys_rst)
    push && !push_pend && size == `URB_SIZE_SEVEN |-> !push_ent.data[7]) else $error("seven-bit data not masked");
  a_data_five: assert property (@(posedge i_clk) disable iff (i_sys_rst)
    push && !push_pend && size == `URB_SIZE_FIVE |-> push_ent.data[7:5] == 3'h0) else $error("five-bit data not masked");
  a_fe_entry: assert property (@(posedge i_clk) disable iff (i_sys_rst)
    push && !push_pend |-> push_ent.fe == !i_frame_stop1) else $error("stored frame error wrong");
  a_upe_keep: assert property (@(posedge i_clk) disable iff (i_sys_rst)
    push && !push_pend && par_en |-> push_ent.parity_error_flag == par_bad) else $error("stored parity error wrong");
  a_overrun_drop: assert property (@(posedge i_clk) disable iff (i_sys_rst)
    overrun |-> !push) else $error("lost frame was stored");
  a_dor_set: assert property (@(posedge i_clk) disable iff (i_sys_rst)
    push && lost_q |-> push_ent.data_overrun_flag) else $error("loss not carried to next entry");
  a_dor_fresh: assert property (@(posedge i_clk) disable iff (i_sys_rst)
    push && !lost_q && !overrun |-> !push_ent.data_overrun_flag) else $error("overrun on clean entry");
  // a frame finishing into a full buffer with no pop is parked
  a_pend_park: assert property (@(posedge i_clk) disable iff (i_sys_rst)
    i_frame_done && rx_en && full && !pop |=> pend_q) else $error("frame not parked when full");
  a_pend_move: assert property (@(posedge i_clk) disable iff (i_sys_rst)
    push_pend && !i_frame_done |=> !pend_q) else $error("parked frame not released");
  a_rx9_head: assert property (@(posedge i_clk) disable iff (i_sys_rst)
    !receive_complete_flag |-> !ctrl_b_v[`URB_CB_RX9]) else $error("ninth bit shown from empty buffer");
endmodule : urb_rx_buffer

// ===== inc/urb_cfg.svh
// urb_cfg.svh: register offsets, field positions and reset values of the receive buffer block
// assumes: included by bare name, definitions only
`ifndef URB_CFG_SVH
`define URB_CFG_SVH
// register byte offsets on the APB
`define URB_OFS_STATUS   12'h000
`define URB_OFS_CTRL_B   12'h004
`define URB_OFS_CTRL_C   12'h008
`define URB_OFS_DATA     12'h00C
// status register fields
`define URB_ST_RXC       7
`define URB_ST_FE        4
`define URB_ST_DOR       3
`define URB_ST_UPE       2
// control register b fields
`define URB_CB_RECEIVE_COMPLETE_IRQ_ENABLE     7
`define URB_CB_RECEIVER_ENABLE      4
`define URB_CB_SIZE2     2
`define URB_CB_RX9       1
`define URB_CB_TX9       0
// control register c fields
`define URB_CC_PEN       5
`define URB_CC_PODD      4
`define URB_CC_STOP2     3
`define URB_CC_SIZE_HI   2
`define URB_CC_SIZE_LO   1
// reset values, buffer depth and nine-bit size code
`define URB_RST_CTRL_B   8'h00
`define URB_RST_CTRL_C   8'h06
`define URB_BUF_DEPTH    2
`define URB_SIZE_NINE    3'h7
// character size codes below eight bits
`define URB_SIZE_FIVE    3'h0
`define URB_SIZE_SIX     3'h1
`define URB_SIZE_SEVEN   3'h2
`endif

// ===== inc/urb_pkg.sv
// urb_pkg.sv: types shared by the receive buffer block
// assumes: urb_cfg.svh is on the include path
package urb_pkg;
  // one buffered frame: ninth bit, error flags and data
  typedef struct packed {
    logic       fe;
    logic       data_overrun_flag;
    logic       parity_error_flag;
    logic       bit9;
    logic [7:0] data;
  } urb_entry_t;
  typedef enum logic [1:0] {
    URB_EMPTY = 2'b00,
    URB_ONE   = 2'b01,
    URB_TWO   = 2'b11
  } urb_fill_t;
endpackage : urb_pkg

// ===== hdl/urb_parity.sv
// urb_parity.sv: parity check of one received frame
// assumes: inputs stable in the cycle of the frame strobe
`timescale 1ns/10ps
`include "urb_cfg.svh"
module urb_parity (
  input  wire logic [7:0] i_data,
  input  wire logic       i_bit9,
  input  wire logic [2:0] i_size,
  input  wire logic       i_par_bit,
  input  wire logic       i_odd,
  output logic            o_err
);
  logic [8:0] bits;
  always_comb begin
    bits = {i_bit9, i_data};
    // only the bits of the configured character size count
    case (i_size)
      `URB_SIZE_FIVE:  bits = {4'h0, i_data[4:0]};
      `URB_SIZE_SIX:   bits = {3'h0, i_data[5:0]};
      `URB_SIZE_SEVEN: bits = {2'h0, i_data[6:0]};
      3'h3:    bits = {1'b0, i_data};
      default: bits = {i_bit9, i_data};
    endcase
    o_err = (^bits) ^ i_par_bit ^ i_odd;
  end
endmodule : urb_parity

// ===== hdl/urb_mem.sv
// urb_mem.sv: two-entry store for buffered frames, registered read data
// assumes: writer and reader never address beyond the depth
`timescale 1ns/10ps
`include "urb_cfg.svh"
module urb_mem (
  input  wire logic                i_clk,
  input  wire logic                i_we,
  input  wire logic                i_waddr,
  input  wire urb_pkg::urb_entry_t i_wdata,
  input  wire logic                i_raddr,
  output urb_pkg::urb_entry_t      o_rdata
);
  import urb_pkg::*;

  urb_entry_t mem_q [`URB_BUF_DEPTH];
  always_ff @(posedge i_clk) begin
    if (i_we) begin
      mem_q[i_waddr] <= i_wdata;
    end
  end
  always_ff @(posedge i_clk) begin
    o_rdata <= (i_we && i_waddr == i_raddr) ? i_wdata : mem_q[i_raddr];
  end
endmodule : urb_mem

// ===== test/urb_tx_model.sv
// urb_tx_model.sv: far-side transmitter, seen as frames from the bit-sampling front end
// assumes: send is called from the bench between rising edges of i_clk
`timescale 1ns/10ps
module urb_tx_model (
  input  wire logic i_clk,
  output logic      o_frame_done,
  output logic [7:0] o_frame_data,
  output logic      o_frame_bit9,
  output logic      o_frame_stop1,
  output logic      o_frame_parity,
  output logic      o_start_det
);
  initial begin
    o_frame_done   = 1'b0;
    o_start_det    = 1'b0;
    o_frame_data   = 8'h00;
    o_frame_bit9   = 1'b0;
    o_frame_stop1  = 1'b1;
    o_frame_parity = 1'b0;
  end
  // only the first stop bit is handed on; after the strobe the lines show the inverse to catch late sampling
  task automatic send(input logic [7:0] d, input logic b9, input logic stp, input logic par);
    @(posedge i_clk);
    o_start_det    <= 1'b1;
    @(posedge i_clk);
    o_start_det    <= 1'b0;
    o_frame_done   <= 1'b1;
    o_frame_data   <= d;
    o_frame_bit9   <= b9;
    o_frame_stop1  <= stp;
    o_frame_parity <= par;
    @(posedge i_clk);
    o_frame_done   <= 1'b0;
    o_frame_data   <= ~d;
    o_frame_bit9   <= ~b9;
    o_frame_stop1  <= ~stp;
    o_frame_parity <= ~par;
  endtask : send
endmodule : urb_tx_model

// ===== test/tb_top.sv
// tb_top.sv: self-checking bench for the receive buffer over APB
// assumes: urb_cfg.svh on the include path; model supplies received frames
`timescale 1ns/10ps
`include "urb_cfg.svh"
module tb_top;
  logic        i_clk, i_sys_rst, psel, penable, pwrite, pready, pslverr, err_seen;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic        fdone, fb9, fstop, fpar, fstart, rx_en, rx_abort, two_stop, tx9, irq;
  logic [7:0]  fdata;
  logic [2:0]  csize;
  int          miscompares, samples_checked;
  localparam logic [11:0] SR = `URB_OFS_STATUS, CB = `URB_OFS_CTRL_B;
  localparam logic [11:0] CC = `URB_OFS_CTRL_C, DR = `URB_OFS_DATA;

  urb_rx_buffer u_urb_rx_buffer (.i_clk(i_clk), .i_sys_rst(i_sys_rst), .i_psel(psel),
    .i_penable(penable), .i_pwrite(pwrite), .i_paddr(paddr), .i_pwdata(pwdata), .i_pstrb(4'hF),
    .o_prdata(prdata), .o_pready(pready), .o_pslverr(pslverr), .i_frame_done(fdone),
    .i_frame_data(fdata), .i_frame_bit9(fb9), .i_frame_stop1(fstop), .i_frame_parity(fpar),
    .i_start_det(fstart), .o_rx_enable(rx_en), .o_rx_abort(rx_abort), .o_char_size(csize),
    .o_two_stop(two_stop), .o_tx_bit9(tx9), .o_rx_irq(irq));
  urb_tx_model u_urb_tx_model (.i_clk(i_clk), .o_frame_done(fdone), .o_frame_data(fdata),
    .o_frame_bit9(fb9), .o_frame_stop1(fstop), .o_frame_parity(fpar), .o_start_det(fstart));

  always #50 i_clk = ~i_clk;

  task automatic complete_run();
    $display("miscompares=%0d samples_checked=%0d", miscompares, samples_checked);
    if (miscompares == 0 && samples_checked > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : complete_run

  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    samples_checked++;
    if (got !== exp) begin
      miscompares++;
      $display("unexpected %s: expected %h, seen %h", nm, exp, got);
    end
  endtask : chk

  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    @(posedge i_clk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge i_clk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge i_clk);
      n++;
    end while (pready !== 1'b1 && n < 16);
    if (pready !== 1'b1) begin
      chk("pready", 32'h0000_0001, 32'(pready));
      complete_run();
    end
    rd       = prdata;
    err_seen = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic rc(input string nm, input logic [11:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0000_0000);
    chk(nm, exp, rd);
  endtask : rc

  function automatic logic [31:0] st(input logic r, input logic f, input logic o, input logic u);
    st = 32'h0000_0000;
    st[`URB_ST_RXC] = r;
    st[`URB_ST_FE]  = f;
    st[`URB_ST_DOR] = o;
    st[`URB_ST_UPE] = u;
  endfunction : st

  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  task automatic t_reset();
    rc("ctrl_b", CB, 32'h0000_0000);
    rc("ctrl_c", CC, 32'h0000_0006);
    rc("status", SR, 32'h0000_0000);
    rc("unmapped", 12'h010, 32'h0000_0000);
    chk("pslverr", 32'h0000_0001, 32'(err_seen));
    chk("pready", 32'h0000_0001, 32'(pready));
    chk("char_size", 32'h0000_0003, 32'(csize));
    chk("two_stop", 32'h0000_0000, 32'(two_stop));
    chk("tx_bit9", 32'h0000_0000, 32'(tx9));
    chk("rx_enable", 32'h0000_0000, 32'(rx_en));
    chk("irq", 32'h0000_0000, 32'(irq));
  endtask : t_reset

  task automatic t_basic();
    apb(1'b1, CB, 32'h0000_0090);
    u_urb_tx_model.send(8'hA5, 1'b0, 1'b1, 1'b0);
    rc("status", SR, st(1, 0, 0, 0));
    chk("irq", 32'h0000_0001, 32'(irq));
    apb(1'b1, SR, 32'h0000_0000);
    chk("irq", 32'h0000_0001, 32'(irq));
    rc("data", DR, 32'h0000_00A5);
    rc("status", SR, st(0, 0, 0, 0));
    chk("irq", 32'h0000_0000, 32'(irq));
  endtask : t_basic

  // nine-bit frames, even parity, two stop bits configured
  task automatic t_nine();
    apb(1'b1, CC, 32'h0000_002E);
    apb(1'b1, CB, 32'h0000_0017);
    u_urb_tx_model.send(8'h5A, 1'b1, 1'b0, 1'b1);
    chk("char_size", 32'h0000_0007, 32'(csize));
    chk("two_stop", 32'h0000_0001, 32'(two_stop));
    chk("tx_bit9", 32'h0000_0001, 32'(tx9));
    u_urb_tx_model.send(8'h3C, 1'b0, 1'b1, 1'b1);
    chk("irq", 32'h0000_0000, 32'(irq));
    apb(1'b1, SR, 32'h0000_0000);
    rc("status", SR, st(1, 1, 0, 0));
    rc("ninth", CB, 32'h0000_0017);
    rc("data", DR, 32'h0000_005A);
    rc("status", SR, st(1, 0, 0, 1));
    rc("ninth", CB, 32'h0000_0015);
    rc("data", DR, 32'h0000_003C);
  endtask : t_nine

  // third frame waits, fourth start bit loses it
  task automatic t_overrun();
    apb(1'b1, CC, 32'h0000_0006);
    apb(1'b1, CB, 32'h0000_0010);
    for (int i = 1; i <= 4; i++) u_urb_tx_model.send(8'(i * 17), 1'b0, 1'b1, 1'b1);
    rc("status", SR, st(1, 0, 0, 0));
    rc("data", DR, 32'h0000_0011);
    rc("data", DR, 32'h0000_0022);
    rc("status", SR, st(1, 0, 1, 0));
    rc("data", DR, 32'h0000_0044);
    u_urb_tx_model.send(8'h55, 1'b0, 1'b1, 1'b0);
    rc("status", SR, st(1, 0, 0, 0));
    rc("data", DR, 32'h0000_0055);
  endtask : t_overrun

  task automatic t_flush();
    int n;
    u_urb_tx_model.send(8'h01, 1'b0, 1'b1, 1'b0);
    u_urb_tx_model.send(8'h02, 1'b0, 1'b1, 1'b0);
    apb(1'b1, CB, 32'h0000_0000);
    @(negedge i_clk);
    chk("abort", 32'h0000_0001, 32'(rx_abort));
    chk("rx_enable", 32'h0000_0000, 32'(rx_en));
    apb(1'b1, CB, 32'h0000_0010);
    rc("status", SR, st(0, 0, 0, 0));
    u_urb_tx_model.send(8'h03, 1'b0, 1'b1, 1'b0);
    u_urb_tx_model.send(8'h04, 1'b0, 1'b1, 1'b0);
    for (n = 0; n < 4; n++) begin
      apb(1'b0, SR, 32'h0000_0000);
      if (rd[`URB_ST_RXC] !== 1'b1) break;
      apb(1'b0, DR, 32'h0000_0000);
    end
    chk("flush_reads", 32'h0000_0002, 32'(n));
  endtask : t_flush

  // seven-bit frames, odd parity
  task automatic t_short();
    apb(1'b1, CC, 32'h0000_0034);
    u_urb_tx_model.send(8'hFF, 1'b0, 1'b1, 1'b0);
    u_urb_tx_model.send(8'hFF, 1'b0, 1'b1, 1'b1);
    rc("status", SR, st(1, 0, 0, 0));
    rc("data", DR, 32'h0000_007F);
    rc("status", SR, st(1, 0, 0, 1));
    rc("data", DR, 32'h0000_007F);
  endtask : t_short

  initial begin
    i_clk = 1'b0;
    i_sys_rst = 1'b1;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0000_0000;
    miscompares = 0;
    samples_checked = 0;
    repeat (12) @(posedge i_clk);
    i_sys_rst <= 1'b0;
    t_reset();
    t_basic();
    t_nine();
    t_overrun();
    t_flush();
    t_short();
    complete_run();
  end
endmodule : tb_top
